// ### tpg_pkg.sv
// Purpose: Constants and types shared by the test pattern generator files
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets are register indices; byte address is four times the index
package tpg_pkg;
    localparam int ADDR_WIDTH = 14;
    localparam int DATA_WIDTH = 16;
    // Register indices
    localparam logic [11:0] CTRL_INDEX = 12'h550;
    localparam logic [11:0] USER_FIRST_INDEX = 12'h551;
    localparam logic [11:0] USER_LAST_INDEX = 12'h558;
    localparam logic [11:0] STATUS_INDEX = 12'h560;
    // Control field positions
    localparam int REPEAT_SEL_BIT = 7;
    localparam int LONG_HOLD_BIT = 5;
    localparam int SHORT_HOLD_BIT = 4;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hbf;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Pattern source codes
    localparam logic [3:0] SRC_NORMAL = 4'h0;
    localparam logic [3:0] SRC_MIDSCALE = 4'h1;
    localparam logic [3:0] SRC_POS_FULL = 4'h2;
    localparam logic [3:0] SRC_NEG_FULL = 4'h3;
    localparam logic [3:0] SRC_CHECKER = 4'h4;
    localparam logic [3:0] SRC_PN_LONG = 4'h5;
    localparam logic [3:0] SRC_PN_SHORT = 4'h6;
    localparam logic [3:0] SRC_TOGGLE = 4'h7;
    localparam logic [3:0] SRC_USER = 4'h8;
    // Fixed output words, two's complement samples
    localparam logic [15:0] WORD_MIDSCALE = 16'h0000;
    localparam logic [15:0] WORD_POS_FULL = 16'h7fff;
    localparam logic [15:0] WORD_NEG_FULL = 16'h8000;
    localparam logic [15:0] WORD_CHECKER = 16'h5555;
    localparam logic [15:0] WORD_ONES = 16'hffff;
    localparam logic [15:0] WORD_ZEROS = 16'h0000;
    // Pseudorandom seeds and taps
    localparam logic [22:0] PN_LONG_SEED = 23'h7fffff;
    localparam logic [8:0] PN_SHORT_SEED = 9'h1ff;
    localparam int PN_LONG_TAP = 18;
    localparam int PN_SHORT_TAP = 4;
    localparam logic [1:0] USER_LAST_SLOT = 2'h3;
    typedef enum logic [1:0] {USER_IDLE, USER_PLAY, USER_DONE} tpg_user_state_type;
endpackage : tpg_pkg

// ### tpg_pn_if.sv
// Purpose: Carries pseudorandom generator controls and words
// Assumes: Single core_clk domain
// Notes: Driven by the top, served by the generator module
interface tpg_pn_if;
    logic long_hold;
    logic short_hold;
    logic [15:0] long_word;
    logic [15:0] short_word;
    modport ctrl (output long_hold, output short_hold, input long_word, input short_word);
    modport gen (input long_hold, input short_hold, output long_word, output short_word);
endinterface : tpg_pn_if

// ### tpg_pn_gen.sv
// Purpose: Long and short pseudorandom sequence generators
// Assumes: Shifts one step per sample clock
// Notes: Hold inputs keep each generator at its seed
module tpg_pn_gen (
    input wire logic core_clk, // Sample clock
    input wire logic reset, // Synchronous reset, active high
    tpg_pn_if.gen pn // Controls and words
);
    logic [22:0] long_reg;
    logic [22:0] long_next;
    logic [8:0] short_reg;
    logic [8:0] short_next;

    // Advance each register unless held
    always_comb begin
        long_next = long_reg;
        short_next = short_reg;
        if (pn.long_hold) begin
            long_next = tpg_pkg::PN_LONG_SEED;
        end else begin
            long_next = {long_reg[21:0],
                long_reg[22] ^ long_reg[tpg_pkg::PN_LONG_TAP - 1]};
        end
        if (pn.short_hold) begin
            short_next = tpg_pkg::PN_SHORT_SEED;
        end else begin
            short_next = {short_reg[7:0],
                short_reg[8] ^ short_reg[tpg_pkg::PN_SHORT_TAP]};
        end
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            long_reg <= tpg_pkg::PN_LONG_SEED;
            short_reg <= tpg_pkg::PN_SHORT_SEED;
        end else begin
            long_reg <= long_next;
            short_reg <= short_next;
        end
    end

    assign pn.long_word = long_reg[15:0];
    assign pn.short_word = {short_reg[6:0], short_reg};
endmodule : tpg_pn_gen

// ### tpg_top.sv
// Purpose: Test pattern generator for the converter output path
// Assumes: APB slave, zero wait states, 250 MHz core_clk
// Assumes: sample_in already runs on core_clk, so it needs no synchroniser
// Notes: Output word feeds the output formatter one per sample clock
module tpg_top (
    input wire logic core_clk, // Sample clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [tpg_pkg::ADDR_WIDTH-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [15:0] sample_in, // Converted sample
    output logic [15:0] sample_out // Word to output formatter
);
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] user_reg [0:7];
    logic [7:0] user_next [0:7];
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [15:0] out_reg;
    logic [15:0] out_next;
    logic toggle_reg;
    logic toggle_next;
    logic [1:0] slot_reg;
    logic [1:0] slot_next;
    tpg_pkg::tpg_user_state_type user_state_reg;
    tpg_pkg::tpg_user_state_type user_state_next;
    logic [11:0] index;
    logic setup;
    logic [31:0] status_word;

    // Pseudorandom generators behind their own carrier
    tpg_pn_if pn ();

    tpg_pn_gen u_pn (
        .core_clk(core_clk),
        .reset(reset),
        .pn(pn)
    );

    // Word index decode, with address in range check
    function automatic logic user_hit(input logic [11:0] idx);
        return idx >= tpg_pkg::USER_FIRST_INDEX && idx <= tpg_pkg::USER_LAST_INDEX;
    endfunction : user_hit

    // Byte slot of a user pattern index
    function automatic logic [2:0] user_slot(input logic [11:0] idx);
        return 3'(idx - tpg_pkg::USER_FIRST_INDEX);
    endfunction : user_slot

    // Pattern word from its two stored bytes
    function automatic logic [15:0] user_word(input logic [7:0] lo, input logic [7:0] hi);
        return {hi, lo};
    endfunction : user_word

    assign index = paddr[13:2];
    assign setup = psel && !penable;

    // Read-only status: done, toggle phase, slot, playing
    assign status_word = {27'h000_0000, user_state_reg == tpg_pkg::USER_DONE,
        toggle_reg, slot_reg, user_state_reg == tpg_pkg::USER_PLAY};

    // APB register access; answer one cycle after setup
    // A write lands at the edge that ends setup, before the access phase
    always_comb begin
        ctrl_next = ctrl_reg;
        user_next = user_reg;
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        if (setup) begin
            pready_next = 1'b1;
            prdata_next = 32'h0000_0000;
            if (index == tpg_pkg::CTRL_INDEX) begin
                if (pwrite) begin
                    ctrl_next = pwdata[7:0] & tpg_pkg::CTRL_WRITE_MASK;
                end
                prdata_next = {24'h00_0000, ctrl_reg};
            end else if (user_hit(index)) begin
                if (pwrite) begin
                    user_next[user_slot(index)] = pwdata[7:0];
                end
                prdata_next = {24'h00_0000, user_reg[user_slot(index)]};
            end else if (index == tpg_pkg::STATUS_INDEX && !pwrite) begin
                prdata_next = status_word;
            end else begin
                pslverr_next = 1'b1;
            end
        end
    end

    // Generator controls
    // A held generator sits at its seed until released
    assign pn.long_hold = ctrl_reg[tpg_pkg::LONG_HOLD_BIT];
    assign pn.short_hold = ctrl_reg[tpg_pkg::SHORT_HOLD_BIT];

    // User pattern sequencer and toggle
    // Leaving user mode parks the sequencer so the next entry starts at pattern one
    always_comb begin
        user_state_next = user_state_reg;
        slot_next = slot_reg;
        toggle_next = ~toggle_reg;
        if (ctrl_reg[3:0] != tpg_pkg::SRC_USER) begin
            user_state_next = tpg_pkg::USER_IDLE;
            slot_next = 2'h0;
        end else begin
            case (user_state_reg)
                tpg_pkg::USER_IDLE: begin
                    user_state_next = tpg_pkg::USER_PLAY;
                    slot_next = 2'h0;
                end
                tpg_pkg::USER_PLAY: begin
                    slot_next = slot_reg + 2'h1;
                    if (slot_reg == tpg_pkg::USER_LAST_SLOT
                            && ctrl_reg[tpg_pkg::REPEAT_SEL_BIT]) begin
                        user_state_next = tpg_pkg::USER_DONE;
                    end
                end
                tpg_pkg::USER_DONE: begin
                    if (!ctrl_reg[tpg_pkg::REPEAT_SEL_BIT]) begin
                        user_state_next = tpg_pkg::USER_PLAY;
                        slot_next = 2'h0;
                    end
                end
                default: begin
                    user_state_next = tpg_pkg::USER_IDLE;
                end
            endcase
        end
    end

    // Output source select
    // Codes with no pattern pass the converted sample
    always_comb begin
        case (ctrl_reg[3:0])
            tpg_pkg::SRC_NORMAL: out_next = sample_in;
            tpg_pkg::SRC_MIDSCALE: out_next = tpg_pkg::WORD_MIDSCALE;
            tpg_pkg::SRC_POS_FULL: out_next = tpg_pkg::WORD_POS_FULL;
            tpg_pkg::SRC_NEG_FULL: out_next = tpg_pkg::WORD_NEG_FULL;
            tpg_pkg::SRC_CHECKER: out_next = toggle_reg ? ~tpg_pkg::WORD_CHECKER
                : tpg_pkg::WORD_CHECKER;
            tpg_pkg::SRC_PN_LONG: out_next = pn.long_word;
            tpg_pkg::SRC_PN_SHORT: out_next = pn.short_word;
            tpg_pkg::SRC_TOGGLE: out_next = toggle_reg ? tpg_pkg::WORD_ZEROS
                : tpg_pkg::WORD_ONES;
            tpg_pkg::SRC_USER: begin
                if (user_state_reg == tpg_pkg::USER_PLAY) begin
                    out_next = user_word(user_reg[{slot_reg, 1'b0}],
                        user_reg[{slot_reg, 1'b1}]);
                end else begin
                    out_next = tpg_pkg::WORD_ZEROS;
                end
            end
            default: out_next = sample_in;
        endcase
    end

    // Register bus state
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_reg <= tpg_pkg::CTRL_RESET;
            for (int i = 0; i < 8; i++) begin
                user_reg[i] <= 8'h00;
            end
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            user_reg <= user_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Sequencer state; the toggle phase runs in every mode
    always_ff @(posedge core_clk) begin
        if (reset) begin
            toggle_reg <= 1'b0;
            slot_reg <= 2'h0;
            user_state_reg <= tpg_pkg::USER_IDLE;
        end else begin
            toggle_reg <= toggle_next;
            slot_reg <= slot_next;
            user_state_reg <= user_state_next;
        end
    end

    // Output word; lands one clock after selection
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out_reg <= tpg_pkg::WORD_ZEROS;
        end else begin
            out_reg <= out_next;
        end
    end

    // Outputs straight from their flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign sample_out = out_reg;
endmodule : tpg_top

// ### tpg_assertions.sv
// Purpose: Checker for the test pattern generator ports
// Assumes: Control written at the edge that ends setup
// Notes: Bound to tpg_top after the module
module tpg_checker (
    input wire logic core_clk, // Sample clock
    input wire logic reset, // Sync reset
    input wire logic psel, // APB select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [tpg_pkg::ADDR_WIDTH-1:0] paddr, // Byte address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [15:0] sample_in, // Sample
    input wire logic [15:0] sample_out // Output word
);
    logic [7:0] ctl_reg, ctl_next;
    logic [3:0] age_reg, age_next, code;
    logic [11:0] idx;
    logic setup, hit, mapped, ok;
    // Shadow of control and cycles since its last write
    always_comb begin
        idx = paddr[13:2];
        setup = psel && !penable;
        mapped = idx == tpg_pkg::CTRL_INDEX || idx == tpg_pkg::STATUS_INDEX
            || (idx >= tpg_pkg::USER_FIRST_INDEX && idx <= tpg_pkg::USER_LAST_INDEX);
        hit = setup && pwrite && idx == tpg_pkg::CTRL_INDEX;
        ctl_next = hit ? (pwdata[7:0] & tpg_pkg::CTRL_WRITE_MASK) : ctl_reg;
        age_next = hit ? 4'h0 : ((age_reg == 4'hf) ? age_reg : age_reg + 4'h1);
        code = ctl_reg[3:0];
        ok = age_reg >= 4'h4;
    end
    // Register the shadow
    always_ff @(posedge core_clk) begin
        ctl_reg <= reset ? 8'h00 : ctl_next;
        age_reg <= reset ? 4'h0 : age_next;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_setup_ready: assert property (setup |=> pready)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_normal_pass: assert property (ok && code == 4'h0 |-> sample_out == $past(sample_in))
        else $error("normal mode not passing samples");
    chk_static_word: assert property (ok && code inside {4'h1, 4'h2, 4'h3} |->
        sample_out == ((code == 4'h1) ? 16'h0000 : (code == 4'h2) ? 16'h7fff : 16'h8000))
        else $error("static word wrong");
    chk_checker_alt: assert property (ok && code == 4'h4 |->
        sample_out inside {16'h5555, 16'haaaa} && sample_out == ~$past(sample_out))
        else $error("checkerboard wrong");
    chk_toggle_alt: assert property (ok && code == 4'h7 |->
        sample_out inside {16'hffff, 16'h0000} && sample_out == ~$past(sample_out))
        else $error("word toggle wrong");
    chk_long_hold: assert property (ok && code == 4'h5 && ctl_reg[5] |-> $stable(sample_out))
        else $error("long generator not held");
    chk_short_hold: assert property (ok && code == 4'h6 && ctl_reg[4] |-> $stable(sample_out))
        else $error("short generator not held");
    chk_user_once: assert property (code == 4'h8 && ctl_reg[7] && age_reg == 4'hf
        |-> sample_out == 16'h0000)
        else $error("single shot not zero after play");
    cover property (setup && pwrite && hit);
    cover property (setup && !mapped);
    cover property (ok && code == 4'h8);
endmodule : tpg_checker

bind tpg_top tpg_checker u_chk (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sample_in, .sample_out);

// ### tpg_conv_model.sv
// Purpose: Converter source and formatter sink around the generator
// Assumes: One word per sample clock
// Notes: Ramp step is odd so neighbouring samples differ
module tpg_conv_model (
    input wire logic core_clk, // Sample clock
    input wire logic reset, // Sync reset
    input wire logic [15:0] sample_out, // Word taken by the formatter
    output logic [15:0] sample_in, // Converted sample ramp
    output logic [31:0] words // Words that replaced a sample
);
    logic [15:0] sent_reg;
    // Ramp out; count words that differ from the sample sent a clock earlier
    always_ff @(posedge core_clk) begin
        sample_in <= reset ? 16'h0000 : sample_in + 16'h0123;
        sent_reg <= reset ? 16'h0000 : sample_in;
        words <= reset ? 32'h0 : words + {31'h0, sample_out != sent_reg};
    end
endmodule : tpg_conv_model

// ### tpg_top_tb.sv
// Purpose: Self-checking bench for the test pattern generator
// Assumes: APB answers in its own time, bounded by the watchdog
// Notes: Words are sampled on the falling edge
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("wrong value %0t got %h want %h", $time, (a), (e)); end end
module tpg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd, words, taken;
    logic [15:0] sample_in, sample_out, prev, w [16];
    logic [15:0] pat [4] = '{16'h1234, 16'hfedc, 16'h00ff, 16'ha5c3};
    logic [15:0] stat [3] = '{16'h0000, 16'h7fff, 16'h8000};
    logic [7:0] m;
    int errors = 0;
    int checks = 0;
    int j;
    tpg_top dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sample_in, .sample_out);
    tpg_conv_model conv (.core_clk, .reset, .sample_out, .sample_in, .words);
    // Clock
    initial begin
        core_clk = 0;
        forever #2 core_clk = ~core_clk;
    end
    // One APB transfer, held until ready
    task apb(input logic wr, input logic [11:0] ix, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Collect output words
    task grab(input int k);
        for (int i = 0; i < k; i++) begin
            @(negedge core_clk);
            w[i] = sample_out;
        end
    endtask : grab
    task test_done;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Watchdog
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        test_done();
    end
    // Tests
    initial begin
        reset <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 14'h0000;
        pwdata <= 32'h0000_0000;
        repeat (12) @(posedge core_clk);
        reset <= 0;
        apb(0, 12'h550, 0);
        `CHK(rd, 32'h0)
        apb(0, 12'h559, 0);
        `CHK({err, rd}, 33'h100000000)
        apb(1, 12'h560, 0);
        `CHK(err, 1'b1)
        apb(1, 12'h550, 32'hff);
        apb(0, 12'h550, 0);
        `CHK(rd[7:0], 8'hbf)
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'(12'h551 + 2 * i), {24'h0, pat[i][7:0]});
            apb(1, 12'(12'h552 + 2 * i), {24'h0, pat[i][15:8]});
        end
        apb(0, 12'h558, 0);
        `CHK(rd[7:0], pat[3][15:8])
        $display("test registers done");
        for (int i = 1; i < 4; i++) begin
            apb(1, 12'h550, 32'h80 | i);
            grab(3);
            `CHK(w[2], stat[i-1])
        end
        apb(1, 12'h550, 0);
        @(negedge core_clk);
        prev = sample_in;
        taken = words;
        @(negedge core_clk);
        `CHK(sample_out, prev)
        `CHK(words, taken)
        $display("test static done");
        for (int i = 0; i < 2; i++) begin
            apb(1, 12'h550, i ? 32'h7 : 32'h4);
            grab(4);
            `CHK(w[3], ~w[2])
            `CHK(w[2] == (i ? 16'hffff : 16'h5555) || w[2] == (i ? 16'h0 : 16'haaaa), 1'b1)
            apb(1, 12'h550, i ? 32'h16 : 32'h25);
            grab(4);
            `CHK(w[3], w[1])
            `CHK(w[1], 16'hffff)
            apb(1, 12'h550, i ? 32'h6 : 32'h5);
            grab(4);
            `CHK(w[1] !== w[2] || w[2] !== w[3], 1'b1)
        end
        $display("test alternating done");
        for (int i = 0; i < 2; i++) begin
            m = i ? 8'h08 : 8'h88;
            apb(1, 12'h550, {24'h0, m});
            grab(16);
            j = 0;
            while (j < 6 && w[j] !== pat[0]) j++;
            for (int k = 0; k < 8; k++)
                `CHK(w[j+k], (m[7] && k > 3) ? 16'h0 : pat[k%4])
            apb(0, 12'h560, 0);
            `CHK({rd[4], rd[0]}, i ? 2'b01 : 2'b10)
        end
        $display("test user done");
        test_done();
    end
endmodule : tpg_top_tb
